// ### hdl/uit_irq.sv
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module uit_irq #(
    parameter int DEPTH = 32,
    parameter int LW    = 6
) (
    input  wire logic          CLK,
    input  wire logic          RESET,
    input  wire logic [4:0]    ADDRESS,
    input  wire logic          READ,
    input  wire logic          WRITE,
    input  wire logic [31:0]   WRITEDATA,
    output logic               WAITREQUEST,
    output logic [31:0]        READDATA,
    output logic               IRQ,
    output logic [7:0]         TX_DATA,
    output logic               TX_WRITE,
    input  wire logic          TX_LOAD,
    input  wire logic          TX_STOP_GEN,
    input  wire logic          TX_BUSY,
    input  wire logic [LW-1:0] TX_LEVEL,
    input  wire logic          RX_STOP,
    input  wire logic          RX_BREAK,
    input  wire logic          RX_PARITY_BAD,
    input  wire logic          RX_FRAME_BAD,
    input  wire logic          RX_FULL,
    input  wire logic [LW-1:0] RX_LEVEL,
    input  wire logic          SIXTEEN_X_BAUD_CLOCK_TICK
);
    // trigger level for a 3-bit select; unused encodings fall back to half
    function automatic logic [LW-1:0] trig(input logic [2:0] sel);
        case (sel)
            uit_pkg::SEL_1_8: trig = LW'(DEPTH / 8);
            uit_pkg::SEL_1_4: trig = LW'(DEPTH / 4);
            uit_pkg::SEL_1_2: trig = LW'(DEPTH / 2);
            uit_pkg::SEL_3_4: trig = LW'(DEPTH * 3 / 4);
            uit_pkg::SEL_7_8: trig = LW'(DEPTH * 7 / 8);
            default:          trig = LW'(DEPTH / 2);
        endcase
    endfunction

    uit_pkg::uit_bus_e          bus_state;
    logic [1:0]                 ctrl;
    logic [5:0]                 lvlsel;
    logic [uit_pkg::NSRC-1:0]   status;
    logic [uit_pkg::NSRC-1:0]   mask;
    logic                       clr_in_send;
    logic                       suppress;
    logic [LW-1:0]              tx_level_q;
    logic [8:0]                 rxto_cnt;
    logic                       rxto_run;
    logic                       req;
    logic                       done;
    logic                       wr_icr;
    logic                       wr_txd;
    logic                       rd_stat;
    logic [LW-1:0]              tx_trig;
    logic [LW-1:0]              rx_trig;
    logic                       tx_fifo_on;
    logic                       rx_fifo_on;
    logic [uit_pkg::NSRC-1:0]   set;
    logic [uit_pkg::NSRC-1:0]   clr;
    logic [31:0]                next_readdata;

    assign req        = READ | WRITE;
    assign done       = req & (bus_state == uit_pkg::UIT_ACK);
    assign wr_icr     = done & WRITE & (ADDRESS == uit_pkg::A_ICR);
    assign wr_txd     = done & WRITE & (ADDRESS == uit_pkg::A_TXDATA);
    assign rd_stat    = done & READ & (ADDRESS == uit_pkg::A_STATUS);
    assign tx_fifo_on = ctrl[uit_pkg::C_TXFEN];
    assign rx_fifo_on = ctrl[uit_pkg::C_RXFEN];
    assign tx_trig    = trig(lvlsel[uit_pkg::S_TXSEL_LO +: 3]);
    assign rx_trig    = trig(lvlsel[uit_pkg::S_RXSEL_LO +: 3]);

    // one wait state: request seen, answered at the following edge
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            bus_state   <= uit_pkg::UIT_IDLE;
            WAITREQUEST <= 1'b1;
        end
        else
        begin
            case (bus_state)
                uit_pkg::UIT_IDLE:
                begin
                    if (req)
                    begin
                        bus_state   <= uit_pkg::UIT_ACK;
                        WAITREQUEST <= 1'b0;
                    end
                end
                uit_pkg::UIT_ACK:
                begin
                    bus_state   <= uit_pkg::UIT_IDLE;
                    WAITREQUEST <= 1'b1;
                end
                default:
                begin
                    bus_state   <= uit_pkg::UIT_IDLE;
                    WAITREQUEST <= 1'b1;
                end
            endcase
        end
    end

    always_comb
    begin
        next_readdata = '0;
        case (ADDRESS)
            uit_pkg::A_CTRL:   next_readdata[1:0] = ctrl;
            uit_pkg::A_LVLSEL: next_readdata[5:0] = lvlsel;
            uit_pkg::A_STATUS: next_readdata[uit_pkg::NSRC-1:0] = status;
            uit_pkg::A_MASK:   next_readdata[uit_pkg::NSRC-1:0] = mask;
            uit_pkg::A_FLAG:   next_readdata[uit_pkg::F_BUSY] = TX_BUSY;
            default:           next_readdata = '0;
        endcase
    end

    // data is latched when the answer is scheduled, so it stands at the ack edge
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            READDATA <= '0;
        else if (READ && bus_state == uit_pkg::UIT_IDLE)
            READDATA <= next_readdata;
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            ctrl   <= uit_pkg::CTRL_RST;
            lvlsel <= uit_pkg::LVLSEL_RST;
            mask   <= uit_pkg::MASK_RST;
        end
        else if (done && WRITE)
        begin
            case (ADDRESS)
                uit_pkg::A_CTRL:   ctrl   <= WRITEDATA[1:0];
                uit_pkg::A_LVLSEL: lvlsel <= WRITEDATA[5:0];
                uit_pkg::A_MASK:   mask   <= WRITEDATA[uit_pkg::NSRC-1:0];
                default:           ctrl   <= ctrl;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            TX_DATA  <= '0;
            TX_WRITE <= 1'b0;
        end
        else
        begin
            TX_WRITE <= wr_txd;
            if (wr_txd)
                TX_DATA <= WRITEDATA[7:0];
        end
    end

    // a clear issued mid-send arms the STOP-time race
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            clr_in_send <= 1'b0;
        else if (wr_icr && WRITEDATA[uit_pkg::B_TX] && TX_BUSY)
            clr_in_send <= 1'b1;
        else if (!TX_BUSY)
            clr_in_send <= 1'b0;
    end

    // the buffer write racing STOP generation loses the next load's interrupt
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            suppress <= 1'b0;
        else if (!tx_fifo_on && clr_in_send && wr_txd && TX_STOP_GEN)
            suppress <= 1'b1;
        else if (TX_LOAD)
            suppress <= 1'b0;
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            tx_level_q <= '0;
        else
            tx_level_q <= TX_LEVEL;
    end

    // timeout counts only while the receive FIFO holds data
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            rxto_cnt <= '0;
            rxto_run <= 1'b0;
        end
        else if (RX_STOP && !RX_FULL)
        begin
            rxto_cnt <= '0;
            rxto_run <= 1'b1;
        end
        else if (RX_LEVEL == '0)
            rxto_run <= 1'b0;
        else if (rxto_run && SIXTEEN_X_BAUD_CLOCK_TICK)
        begin
            if (rxto_cnt == uit_pkg::RXTO_LAST)
                rxto_run <= 1'b0;
            rxto_cnt <= rxto_cnt + 9'h001;
        end
    end

    always_comb
    begin
        set = '0;
        if (tx_fifo_on)
            set[uit_pkg::B_TX] = (TX_LEVEL == tx_trig) && (tx_level_q != tx_trig);
        else
            set[uit_pkg::B_TX] = TX_LOAD && !suppress;
        if (rx_fifo_on)
            set[uit_pkg::B_RX] = RX_STOP && !RX_FULL && (RX_LEVEL == rx_trig);
        else
            set[uit_pkg::B_RX] = RX_STOP;
        set[uit_pkg::B_RXTO] = rxto_run && SIXTEEN_X_BAUD_CLOCK_TICK
                               && (rxto_cnt == uit_pkg::RXTO_LAST);
        set[uit_pkg::B_PAR]  = RX_PARITY_BAD;
        set[uit_pkg::B_FRM]  = RX_FRAME_BAD;
        set[uit_pkg::B_BRK]  = RX_STOP && RX_BREAK;
        set[uit_pkg::B_OVR]  = RX_STOP && RX_FULL;
    end

    always_comb
    begin
        clr = '0;
        // only bits the read reported are cleared; one set since then stays
        if (rd_stat)
            clr = READDATA[uit_pkg::NSRC-1:0];
        if (wr_icr)
            clr = clr | WRITEDATA[uit_pkg::NSRC-1:0];
        if (!tx_fifo_on && wr_txd)
            clr[uit_pkg::B_TX] = 1'b1;
        if (tx_fifo_on && TX_LEVEL > tx_trig)
            clr[uit_pkg::B_TX] = 1'b1;
    end

    // sticky: set wins over any clear in the same cycle
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            status <= '0;
        else
            status <= (status & ~clr) | set;
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            IRQ <= 1'b0;
        else
            IRQ <= |(status & mask);
    end
endmodule
`default_nettype wire

// ### hdl/uit_pkg.sv
// Functional notes
// - Without the transmit FIFO, the transmit interrupt rises when the held word moves into the shift register.
// - Without the transmit FIFO, a write into the holding buffer clears a pending transmit interrupt.
// - Writing one to the transmit clear bit clears a pending transmit interrupt.
// - After a software clear during a send, a buffer write coinciding with STOP generation suppresses that word's interrupt.
// - With the transmit FIFO on, the transmit interrupt rises when the fill level reaches the selected level.
// - Transmit select 000 means one eighth full, four entries.
// - With the transmit FIFO on, the interrupt clears above the selected level and rises again on falling back to it.
// - An overrun is flagged when a STOP bit arrives while the receive FIFO is full.
// - A break interrupt rises after the STOP bit position of the frame that carried the break.
// - A parity error is flagged once a sampled parity bit is found wrong.
// - A framing error is flagged after the bit that violates the expected frame end.
// - A receive timeout rises 511 sixteen-times baud ticks after data is stored in the receive FIFO.
// - Without the receive FIFO, each STOP bit raises the receive interrupt.
// - With the receive FIFO, the STOP bit of the frame that reaches the trigger level raises the receive interrupt.
package uit_pkg;
    localparam int          AW          = 5;
    localparam logic [4:0]  A_CTRL      = 5'h00;
    localparam logic [4:0]  A_LVLSEL    = 5'h04;
    localparam logic [4:0]  A_STATUS    = 5'h08;
    localparam logic [4:0]  A_MASK      = 5'h0C;
    localparam logic [4:0]  A_ICR       = 5'h10;
    localparam logic [4:0]  A_FLAG      = 5'h14;
    localparam logic [4:0]  A_TXDATA    = 5'h18;
    localparam int          NSRC        = 7;
    localparam int          B_TX        = 0;
    localparam int          B_RX        = 1;
    localparam int          B_RXTO      = 2;
    localparam int          B_PAR       = 3;
    localparam int          B_FRM       = 4;
    localparam int          B_BRK       = 5;
    localparam int          B_OVR       = 6;
    localparam int          C_TXFEN     = 0;
    localparam int          C_RXFEN     = 1;
    localparam int          S_TXSEL_LO  = 0;
    localparam int          S_RXSEL_LO  = 3;
    localparam int          F_BUSY      = 0;
    localparam logic [1:0]  CTRL_RST    = 2'h0;
    localparam logic [5:0]  LVLSEL_RST  = 6'h00;
    localparam logic [6:0]  MASK_RST    = 7'h00;
    localparam int          RXTO_TICKS  = 511;
    localparam logic [8:0]  RXTO_LAST   = 9'(RXTO_TICKS - 1);
    localparam logic [2:0]  SEL_1_8     = 3'h0;
    localparam logic [2:0]  SEL_1_4     = 3'h1;
    localparam logic [2:0]  SEL_1_2     = 3'h2;
    localparam logic [2:0]  SEL_3_4     = 3'h3;
    localparam logic [2:0]  SEL_7_8     = 3'h4;

    typedef enum logic [1:0] {
        UIT_IDLE = 2'h0,
        UIT_ACK  = 2'h1
    } uit_bus_e;
endpackage

// ### dv/uit_node.sv
`timescale 1ns/100ps
`default_nettype none
module uit_node (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [4:0] ev,
    output logic            load,
    output logic            stop_gen,
    output logic            rx_stop,
    output logic            par_bad,
    output logic            frm_bad,
    output logic            tick
);
    logic [1:0] div;

    // free-running tick every four clocks keeps the long receive wait short
    always_ff @(posedge clk or posedge reset)
        if (reset)
            div <= 2'h0;
        else
            div <= div + 2'h1;

    assign tick = (div == 2'h3);
    assign {load, stop_gen, rx_stop, par_bad, frm_bad} = ev;
endmodule
`default_nettype wire

// ### dv/uit_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module uit_monitor #(
    parameter int DEPTH = 32,
    parameter int LW    = 6
) (
    input  wire logic          CLK,
    input  wire logic          RESET,
    input  wire logic [4:0]    ADDRESS,
    input  wire logic          READ,
    input  wire logic          WRITE,
    input  wire logic [31:0]   WRITEDATA,
    input  wire logic          WAITREQUEST,
    input  wire logic          IRQ,
    input  wire logic          TX_LOAD,
    input  wire logic [LW-1:0] TX_LEVEL,
    input  wire logic          RX_STOP,
    input  wire logic          RX_FULL,
    input  wire logic          RX_PARITY_BAD,
    input  wire logic          RX_FRAME_BAD
);
    // level select assumed at reset value: four entries
    localparam logic [LW-1:0] TX_TRIG = LW'(4);
    logic       wr_done;
    logic [1:0] fen;
    logic [6:0] msk;

    assign wr_done = WRITE && !WAITREQUEST;

    always_ff @(posedge CLK or posedge RESET)
        if (RESET)
        begin
            fen <= 2'h0;
            msk <= 7'h00;
        end
        else if (wr_done && ADDRESS == uit_pkg::A_CTRL)
            fen <= WRITEDATA[1:0];
        else if (wr_done && ADDRESS == uit_pkg::A_MASK)
            msk <= WRITEDATA[6:0];

    default clocking dc @(posedge CLK);
    endclocking
    default disable iff (RESET);

    property p_tx_load; TX_LOAD && !fen[0] && msk[0] |=> ##1 IRQ; endproperty
    a_tx_load: assert property (p_tx_load) else $error("tx load no irq");
    property p_tx_wr; wr_done && ADDRESS == uit_pkg::A_TXDATA && !fen[0] && msk == 7'h01
        && !TX_LOAD ##1 !TX_LOAD |=> !IRQ; endproperty
    a_tx_wr: assert property (p_tx_wr) else $error("data write kept irq");
    property p_tx_clr; wr_done && ADDRESS == uit_pkg::A_ICR && WRITEDATA[0] && !fen[0]
        && msk == 7'h01 && !TX_LOAD ##1 !TX_LOAD |=> !IRQ; endproperty
    a_tx_clr: assert property (p_tx_clr) else $error("clear bit kept irq");
    property p_tx_hit; fen[0] && msk[0] && TX_LEVEL == TX_TRIG
        && $past(TX_LEVEL) != TX_TRIG |=> ##1 IRQ; endproperty
    a_tx_hit: assert property (p_tx_hit) else $error("tx level no irq");
    property p_tx_above; (fen[0] && msk == 7'h01 && TX_LEVEL > TX_TRIG) [*2] |=> !IRQ; endproperty
    a_tx_above: assert property (p_tx_above) else $error("irq above level");
    property p_rx_stop; RX_STOP && !RX_FULL && !fen[1] && msk[1] |=> ##1 IRQ; endproperty
    a_rx_stop: assert property (p_rx_stop) else $error("stop bit no irq");
    property p_ovr; RX_STOP && RX_FULL && msk[6] |=> ##1 IRQ; endproperty
    a_ovr: assert property (p_ovr) else $error("overrun no irq");
    property p_rx_err; (RX_PARITY_BAD && msk[3]) || (RX_FRAME_BAD && msk[4]) |=> ##1 IRQ;
    endproperty
    a_rx_err: assert property (p_rx_err) else $error("rx error no irq");
    property p_hold; IRQ && !fen[0] && !READ && !WRITE && !$past(READ) && !$past(WRITE)
        |=> IRQ; endproperty
    a_hold: assert property (p_hold) else $error("irq dropped alone");
endmodule

bind uit_irq uit_monitor #(.DEPTH(DEPTH), .LW(LW)) u_uit_monitor (.CLK, .RESET, .ADDRESS,
    .READ, .WRITE, .WRITEDATA, .WAITREQUEST, .IRQ, .TX_LOAD, .TX_LEVEL, .RX_STOP, .RX_FULL,
    .RX_PARITY_BAD, .RX_FRAME_BAD);
`default_nettype wire

// ### dv/uart_interrupt_timing_test.sv
`timescale 1ns/100ps
`default_nettype none
module uart_interrupt_timing_test;
    typedef struct packed {
        logic [1:0] c;
        logic [4:0] e;
        logic       b;
        logic       f;
        logic [5:0] r;
        logic [5:0] t;
        logic [6:0] x;
    } uit_row_s;
    logic        CLK = 1'b0;
    logic        RESET = 1'b1;
    logic        READ = 1'b0;
    logic        WRITE = 1'b0;
    logic        TX_BUSY = 1'b0;
    logic        RX_BREAK = 1'b0;
    logic        RX_FULL = 1'b0;
    logic [4:0]  ADDRESS = 5'h00;
    logic [4:0]  ev = 5'h00;
    logic [5:0]  TX_LEVEL = 6'h00;
    logic [5:0]  RX_LEVEL = 6'h00;
    logic [31:0] WRITEDATA = 32'h0;
    logic [31:0] READDATA;
    logic [31:0] q;
    logic [7:0]  TX_DATA;
    logic        WAITREQUEST, IRQ, TX_WRITE, TX_LOAD, TX_STOP_GEN;
    logic        RX_STOP, RX_PARITY_BAD, RX_FRAME_BAD, SIXTEEN_X_BAUD_CLOCK_TICK;
    int          bad_count = 0;
    int          n_tests = 0;
    int          n;
    // event bits: load, stop generation, rx stop, parity, framing
    uit_row_s    rows [10] = '{
        '{2'h0, 5'h10, 1'h0, 1'h0, 6'h00, 6'h00, 7'h01},
        '{2'h1, 5'h00, 1'h0, 1'h0, 6'h00, 6'h04, 7'h01},
        '{2'h1, 5'h00, 1'h0, 1'h0, 6'h00, 6'h05, 7'h00},
        '{2'h0, 5'h04, 1'h0, 1'h0, 6'h01, 6'h00, 7'h02},
        '{2'h0, 5'h04, 1'h1, 1'h0, 6'h01, 6'h00, 7'h22},
        '{2'h0, 5'h02, 1'h0, 1'h0, 6'h00, 6'h00, 7'h08},
        '{2'h0, 5'h01, 1'h0, 1'h0, 6'h00, 6'h00, 7'h10},
        '{2'h2, 5'h04, 1'h0, 1'h0, 6'h04, 6'h00, 7'h02},
        '{2'h2, 5'h04, 1'h0, 1'h0, 6'h03, 6'h00, 7'h00},
        '{2'h2, 5'h04, 1'h0, 1'h1, 6'h20, 6'h00, 7'h40}};

    uit_irq #(.DEPTH(32), .LW(6)) u_uit_irq (.CLK, .RESET, .ADDRESS, .READ, .WRITE,
        .WRITEDATA, .WAITREQUEST, .READDATA, .IRQ, .TX_DATA, .TX_WRITE, .TX_LOAD,
        .TX_STOP_GEN, .TX_BUSY, .TX_LEVEL, .RX_STOP, .RX_BREAK, .RX_PARITY_BAD,
        .RX_FRAME_BAD, .RX_FULL, .RX_LEVEL, .SIXTEEN_X_BAUD_CLOCK_TICK);
    uit_node u_uit_node (.clk(CLK), .reset(RESET), .ev, .load(TX_LOAD),
        .stop_gen(TX_STOP_GEN), .rx_stop(RX_STOP), .par_bad(RX_PARITY_BAD),
        .frm_bad(RX_FRAME_BAD), .tick(SIXTEEN_X_BAUD_CLOCK_TICK));

    always #4 CLK = ~CLK;

    task automatic end_sim;
        if (bad_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge CLK);
        READ <= ~w;
        WRITE <= w;
        ADDRESS <= a;
        WRITEDATA <= d;
        do
            @(posedge CLK);
        while (WAITREQUEST !== 1'b0);
        q = READDATA;
        READ <= 1'b0;
        WRITE <= 1'b0;
    endtask

    task automatic pulse(input logic [4:0] e);
        @(posedge CLK);
        ev <= e;
        @(posedge CLK);
        ev <= 5'h00;
        repeat (2) @(posedge CLK);
    endtask

    initial
    begin
        repeat (16) @(posedge CLK);
        RESET <= 1'b0;
        TX_BUSY <= 1'b1;
        chk(WAITREQUEST, 1'b1);
        chk(IRQ, 1'b0);
        bus(1'b0, uit_pkg::A_FLAG, 32'h0);
        chk(q, 32'h1);
        bus(1'b0, 5'h1C, 32'h0);
        chk(q, 32'h0);
        TX_BUSY <= 1'b0;
        bus(1'b1, uit_pkg::A_MASK, 32'h7F);
        foreach (rows[i])
        begin
            bus(1'b1, uit_pkg::A_CTRL, {30'h0, rows[i].c});
            @(posedge CLK);
            ev <= rows[i].e;
            RX_BREAK <= rows[i].b;
            RX_FULL <= rows[i].f;
            RX_LEVEL <= rows[i].r;
            TX_LEVEL <= rows[i].t;
            @(posedge CLK);
            {RX_BREAK, RX_FULL, RX_LEVEL, TX_LEVEL, ev} <= 19'h0;
            repeat (3) @(posedge CLK);
            chk(IRQ, rows[i].x != 7'h00);
            bus(1'b0, uit_pkg::A_STATUS, 32'h0);
            chk(q, rows[i].x);
        end
        bus(1'b1, uit_pkg::A_MASK, 32'h1);
        bus(1'b1, uit_pkg::A_CTRL, 32'h0);
        pulse(5'h10);
        chk(IRQ, 1'b1);
        bus(1'b1, uit_pkg::A_TXDATA, 32'hA5);
        @(posedge CLK);
        chk(TX_WRITE, 1'b1);
        @(posedge CLK);
        chk(IRQ, 1'b0);
        chk(TX_WRITE, 1'b0);
        chk(TX_DATA, 8'hA5);
        pulse(5'h10);
        bus(1'b1, uit_pkg::A_ICR, 32'h1);
        repeat (2) @(posedge CLK);
        chk(IRQ, 1'b0);
        // stop generation lands on the write's completing edge
        TX_BUSY <= 1'b1;
        bus(1'b1, uit_pkg::A_MASK, 32'h0);
        bus(1'b1, uit_pkg::A_ICR, 32'h1);
        fork
            bus(1'b1, uit_pkg::A_TXDATA, 32'h5A);
            begin
                repeat (2) @(posedge CLK);
                ev <= 5'h08;
                @(posedge CLK);
                ev <= 5'h00;
            end
        join
        pulse(5'h10);
        bus(1'b0, uit_pkg::A_STATUS, 32'h0);
        chk(q, 32'h0);
        TX_BUSY <= 1'b0;
        bus(1'b1, uit_pkg::A_TXDATA, 32'h3C);
        pulse(5'h10);
        bus(1'b0, uit_pkg::A_STATUS, 32'h0);
        chk(q, 32'h1);
        bus(1'b1, uit_pkg::A_MASK, 32'h4);
        @(posedge CLK);
        RX_LEVEL <= 6'h01;
        ev <= 5'h04;
        @(posedge CLK);
        ev <= 5'h00;
        n = 0;
        while (IRQ !== 1'b1 && n < 3000)
        begin
            @(posedge CLK);
            n++;
        end
        chk(n > uit_pkg::RXTO_TICKS * 4 - 8 && n < uit_pkg::RXTO_TICKS * 4 + 12, 1'b1);
        RX_LEVEL <= 6'h00;
        bus(1'b0, uit_pkg::A_STATUS, 32'h0);
        chk(q, 32'h6);
        // receive trigger moved to eight entries, transmit select left at 000
        bus(1'b1, uit_pkg::A_LVLSEL, 32'h08);
        bus(1'b1, uit_pkg::A_CTRL, 32'h2);
        @(posedge CLK);
        RX_LEVEL <= 6'h08;
        ev <= 5'h04;
        @(posedge CLK);
        ev <= 5'h00;
        RX_LEVEL <= 6'h00;
        bus(1'b0, uit_pkg::A_STATUS, 32'h0);
        chk(q, 32'h2);
        bus(1'b1, uit_pkg::A_MASK, 32'h1);
        bus(1'b1, uit_pkg::A_CTRL, 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            @(posedge CLK);
            TX_LEVEL <= (i == 1) ? 6'h05 : 6'h04;
            repeat (3) @(posedge CLK);
            chk(IRQ, i != 1);
        end
        end_sim;
    end

    initial
    begin
        repeat (20000) @(posedge CLK);
        bad_count++;
        end_sim;
    end
endmodule
`default_nettype wire
